/* hw/umsft_pkg.sv */
// Constants, types and state layout for the modem status and FIFO test block
package umsft_pkg;

  // Bus and field widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;
  localparam int MODEM_W = 4;
  localparam int INT_W = 3;
  localparam int LPD_W = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MSR = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SCR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_LOW_POWER_DIVISOR_LOW = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_LOW_POWER_DIVISOR_HIGH = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_ALIAS_LO = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_ALIAS_HI = 8'h6C;
  localparam logic [ADDR_W-1:0] OFS_FAR = 8'h70;
  localparam logic [ADDR_W-1:0] OFS_TFR = 8'h74;
  localparam logic [ADDR_W-1:0] OFS_RFW = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'hA0;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'hA4;
  localparam logic [ADDR_W-1:0] ADDR_WORD_MASK = 8'hFC;

  // Field positions
  localparam int FAR_EN_BIT = 0;
  localparam int HTRANS_ACT_BIT = 1;
  localparam int INT_MODEM = 0;
  localparam int INT_INJECT = 1;
  localparam int INT_ALIAS_WR = 2;

  // Reset and response values
  localparam logic [MODEM_W-1:0] MODEM_IDLE = 4'hF;
  localparam logic [MODEM_W-1:0] CHG_RST = 4'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [INT_W-1:0] INT_RST = 3'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic RESP_OKAY = 1'b0;

  // Active-low modem lines as they arrive on the pins
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } umsft_modem_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_READ = 3'b010,
    BUS_WRITE = 3'b100
  } umsft_bus_t;

  typedef struct packed {
    umsft_bus_t bus;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rdata;
    logic [MODEM_W-1:0] sync1;
    logic [MODEM_W-1:0] sync2;
    logic [MODEM_W-1:0] prev;
    logic [MODEM_W-1:0] chg;
    logic [BYTE_W-1:0] scratch;
    logic [BYTE_W-1:0] lpdl;
    logic [BYTE_W-1:0] lpdh;
    logic fifo_test_enable;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic thr_wr;
    logic [BYTE_W-1:0] thr_data;
    logic inj_wr;
    logic [BYTE_W-1:0] inj_data;
  } umsft_state_t;

  localparam umsft_state_t STATE_RST = '{
    bus: BUS_IDLE,
    addr: ADDR_RST,
    rdata: WORD_ZERO,
    sync1: MODEM_IDLE,
    sync2: MODEM_IDLE,
    prev: MODEM_IDLE,
    chg: CHG_RST,
    scratch: BYTE_RST,
    lpdl: BYTE_RST,
    lpdh: BYTE_RST,
    fifo_test_enable: 1'b0,
    int_stat: INT_RST,
    int_mask: INT_RST,
    thr_wr: 1'b0,
    thr_data: BYTE_RST,
    inj_wr: 1'b0,
    inj_data: BYTE_RST
  };

endpackage

/* hw/umsft_top.sv */
// Modem status, scratch, low-power divisor, alias windows and FIFO test access
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns

// Overview of operation
// - Data-set-ready bit shows inverted line level
// - Clear-to-send bit shows inverted line level
// - Carrier-detect change flag set on line change
// - Ring-indicator change flag set on line change
// - Data-set-ready change flag set on line change
// - Clear-to-send change flag set on line change
// - Scratch byte stores software data only
// - Two bytes form low-power divisor, reset zero
// - Alias window reads return receive buffer
// - Alias window writes load transmit holding
// - Access register bit 0 enables test mode
// - Enable write ignored without option, always readable
// - Test mode read returns transmit FIFO head, or holding without FIFOs
// - Test mode write injects into receive side
module umsft_top #(
  parameter bit LP_RX_EN = 1'b1,
  parameter bit SHADOW_EN = 1'b1,
  parameter bit FIFO_ACCESS_EN = 1'b1,
  parameter bit FIFO_EN = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Modem lines from the peer, active low, asynchronous
  input wire umsft_pkg::umsft_modem_t modem_n_i,
  // Neighbouring port logic
  input wire logic line_control_dlab_i,
  input wire logic [7:0] receive_buffer_i,
  input wire logic [7:0] transmit_holding_i,
  input wire logic [7:0] tx_fifo_head_i,
  output logic receive_buffer_read_o,
  output logic transmit_holding_write_o,
  output logic [7:0] transmit_holding_data_o,
  output logic tx_fifo_peek_read_o,
  output logic rx_fifo_inject_o,
  output logic receive_buffer_inject_o,
  output logic [7:0] inject_data_o,
  output logic fifo_test_mode_o,
  output logic [15:0] low_power_divisor_o,
  // Interrupt
  output logic irq_o
);
  import umsft_pkg::*;

  umsft_state_t r;
  umsft_state_t n;

  logic addr_take;
  logic rd_cycle;
  logic wr_cycle;
  logic alias_hit;
  logic msr_read;
  logic tfr_read;
  logic [MODEM_W-1:0] modem_edge;
  logic [BYTE_W-1:0] wbyte;
  logic alias_write;
  logic inject_write;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;

  function automatic logic [DATA_W-1:0] zx_byte(input logic [BYTE_W-1:0] b);
    return {{(DATA_W-BYTE_W){1'b0}}, b};
  endfunction

  function automatic logic [DATA_W-1:0] zx_int(input logic [INT_W-1:0] b);
    return {{(DATA_W-INT_W){1'b0}}, b};
  endfunction

  // Address phase is only taken while the bus is ready
  assign addr_take = hsel_i && htrans_i[HTRANS_ACT_BIT] && hready_i;
  assign rd_cycle = (r.bus == BUS_READ);
  assign wr_cycle = (r.bus == BUS_WRITE);
  assign wbyte = hwdata_i[BYTE_W-1:0];

  // Alias window closes while the divisor latch is selected
  assign alias_hit = SHADOW_EN && !line_control_dlab_i &&
                     (r.addr >= OFS_ALIAS_LO) && (r.addr <= OFS_ALIAS_HI);

  // Third stage compares against the second; first stage stays private
  assign modem_edge = r.sync2 ^ r.prev;
  assign msr_read = rd_cycle && (r.addr == OFS_MSR);
  assign tfr_read = rd_cycle && (r.addr == OFS_TFR) && FIFO_ACCESS_EN && r.fifo_test_enable;

  assign alias_write = wr_cycle && alias_hit;
  assign inject_write = wr_cycle && (r.addr == OFS_RFW) && FIFO_ACCESS_EN && r.fifo_test_enable;

  assign int_set[INT_MODEM] = |modem_edge;
  assign int_set[INT_INJECT] = inject_write;
  assign int_set[INT_ALIAS_WR] = alias_write;
  assign int_clr = (wr_cycle && (r.addr == OFS_INT_STAT)) ? hwdata_i[INT_W-1:0] : INT_RST;

  always_comb begin
    n = r;
    n.thr_wr = 1'b0;
    n.inj_wr = 1'b0;

    // Two-stage synchroniser plus one history stage
    n.sync1 = modem_n_i;
    n.sync2 = r.sync1;
    n.prev = r.sync2;

    // A change in the read cycle survives the clear
    n.chg = (r.chg & ~{MODEM_W{msr_read}}) | modem_edge;

    // Sticky events, set beats write-one-to-clear
    n.int_stat = (r.int_stat & ~int_clr) | int_set;

    // Write data phase
    if (wr_cycle) begin
      unique case (r.addr)
        OFS_SCR: begin
          n.scratch = wbyte;
        end
        OFS_LOW_POWER_DIVISOR_LOW: begin
          if (LP_RX_EN) begin
            n.lpdl = wbyte;
          end
        end
        OFS_LOW_POWER_DIVISOR_HIGH: begin
          if (LP_RX_EN) begin
            n.lpdh = wbyte;
          end
        end
        OFS_FAR: begin
          if (FIFO_ACCESS_EN) begin
            n.fifo_test_enable = hwdata_i[FAR_EN_BIT];
          end
        end
        OFS_RFW: begin
          if (inject_write) begin
            n.inj_wr = 1'b1;
            n.inj_data = wbyte;
          end
        end
        OFS_INT_MASK: begin
          n.int_mask = hwdata_i[INT_W-1:0];
        end
        default: begin
          if (alias_write) begin
            n.thr_wr = 1'b1;
            n.thr_data = wbyte;
          end
        end
      endcase
    end

    // Read data is formed in the wait cycle so a preceding write is seen
    if (rd_cycle) begin
      unique case (r.addr)
        OFS_MSR: begin
          n.rdata = {{(DATA_W-2*MODEM_W){1'b0}}, ~r.sync2, r.chg};
        end
        OFS_SCR: begin
          n.rdata = zx_byte(r.scratch);
        end
        OFS_LOW_POWER_DIVISOR_LOW: begin
          n.rdata = LP_RX_EN ? zx_byte(r.lpdl) : WORD_ZERO;
        end
        OFS_LOW_POWER_DIVISOR_HIGH: begin
          n.rdata = LP_RX_EN ? zx_byte(r.lpdh) : WORD_ZERO;
        end
        OFS_FAR: begin
          n.rdata = {{(DATA_W-1){1'b0}}, r.fifo_test_enable};
        end
        OFS_TFR: begin
          if (tfr_read) begin
            n.rdata = zx_byte(FIFO_EN ? tx_fifo_head_i : transmit_holding_i);
          end else begin
            n.rdata = WORD_ZERO;
          end
        end
        OFS_INT_STAT: begin
          n.rdata = zx_int(r.int_stat);
        end
        OFS_INT_MASK: begin
          n.rdata = zx_int(r.int_mask);
        end
        default: begin
          n.rdata = alias_hit ? zx_byte(receive_buffer_i) : WORD_ZERO;
        end
      endcase
    end

    // Next bus phase; a read holds hready low for one cycle
    if (addr_take) begin
      n.addr = haddr_i[ADDR_W-1:0] & ADDR_WORD_MASK;
      n.bus = hwrite_i ? BUS_WRITE : BUS_READ;
    end else begin
      n.bus = BUS_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= STATE_RST;
    end else begin
      r <= n;
    end
  end

  // Bus answer; every transfer ends OKAY
  assign hrdata_o = r.rdata;
  assign hreadyout_o = !rd_cycle;
  assign hresp_o = RESP_OKAY;

  // Side effects toward the receive buffer and transmit FIFO
  assign receive_buffer_read_o = rd_cycle && alias_hit &&
                                 !(r.addr inside {OFS_MSR, OFS_SCR, OFS_LOW_POWER_DIVISOR_LOW, OFS_LOW_POWER_DIVISOR_HIGH,
                                                  OFS_FAR, OFS_TFR, OFS_INT_STAT,
                                                  OFS_INT_MASK});
  assign tx_fifo_peek_read_o = tfr_read;
  assign transmit_holding_write_o = r.thr_wr;
  assign transmit_holding_data_o = r.thr_data;
  assign rx_fifo_inject_o = r.inj_wr && FIFO_EN;
  assign receive_buffer_inject_o = r.inj_wr && !FIFO_EN;
  assign inject_data_o = r.inj_data;

  // Configuration toward the serial engine
  assign fifo_test_mode_o = r.fifo_test_enable;
  assign low_power_divisor_o = {r.lpdh, r.lpdl};

  assign irq_o = |(r.int_stat & r.int_mask);

endmodule

/* bench/umsft_sva.sv */
// Port-level temporal checks for the modem status and FIFO test block
`timescale 1ns/1ns
module umsft_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  // Modem lines and port side
  input wire umsft_pkg::umsft_modem_t modem_n_i,
  input wire logic line_control_dlab_i,
  input wire logic [7:0] receive_buffer_i,
  input wire logic [7:0] tx_fifo_head_i,
  input wire logic receive_buffer_read_o,
  input wire logic transmit_holding_write_o,
  input wire logic [7:0] transmit_holding_data_o,
  input wire logic tx_fifo_peek_read_o,
  input wire logic rx_fifo_inject_o,
  input wire logic [7:0] inject_data_o,
  input wire logic fifo_test_mode_o,
  input wire logic [15:0] low_power_divisor_o
);
  import umsft_pkg::*;
  logic [3:0] prev_r;
  logic [3:0] stab_r;
  wire tk = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] a = haddr_i[7:0] & ADDR_WORD_MASK;
  wire [7:0] wlo = hwdata_i[7:0];
  wire win = (a >= OFS_ALIAS_LO) && (a <= OFS_ALIAS_HI);
  // Level checks only trust lines that have settled past the synchroniser
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_r <= MODEM_IDLE;
      stab_r <= 4'h0;
    end else begin
      prev_r <= modem_n_i;
      stab_r <= (modem_n_i != prev_r) ? 4'h0 : stab_r + {3'h0, stab_r != 4'hF};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wr(logic [7:0] o); tk && hwrite_i && a == o; endsequence
  sequence s_rd(logic [7:0] o); tk && !hwrite_i && a == o; endsequence
  sequence s_rd_wait; !hreadyout_o ##1 hreadyout_o; endsequence
  AST_MSR_LEVELS: assert property (s_rd(OFS_MSR) ##0 stab_r > 4'h4 |=>
    s_rd_wait ##0 hrdata_o[7:4] == ~modem_n_i) else $error("modem levels wrong");
  AST_RBR_ALIAS: assert property (tk && !hwrite_i && win && !line_control_dlab_i |=>
    receive_buffer_read_o ##0 s_rd_wait ##0 hrdata_o == {24'h00_0000, $past(receive_buffer_i)})
    else $error("alias read wrong");
  AST_ALIAS_SHUT: assert property (tk && !hwrite_i && win && line_control_dlab_i |=>
    !receive_buffer_read_o ##1 hrdata_o == WORD_ZERO) else $error("closed alias read");
  AST_THR_ALIAS: assert property (tk && hwrite_i && win && !line_control_dlab_i |=>
    ##1 transmit_holding_write_o && transmit_holding_data_o == $past(wlo))
    else $error("alias write lost");
  AST_SCR_QUIET: assert property (s_wr(OFS_SCR) |=> ##1 !transmit_holding_write_o &&
    !rx_fifo_inject_o && $stable(low_power_divisor_o)) else $error("scratch side effect");
  AST_LPD_LOW: assert property (s_wr(OFS_LOW_POWER_DIVISOR_LOW) |=>
    ##1 low_power_divisor_o[7:0] == $past(wlo)) else $error("divisor low wrong");
  AST_LPD_HIGH: assert property (s_wr(OFS_LOW_POWER_DIVISOR_HIGH) |=>
    ##1 low_power_divisor_o[15:8] == $past(wlo)) else $error("divisor high wrong");
  AST_FAR_MODE: assert property (s_wr(OFS_FAR) |=>
    ##1 {7'h00, fifo_test_mode_o} == ($past(wlo) & 8'h01)) else $error("test mode bit wrong");
  AST_PEEK: assert property (s_rd(OFS_TFR) ##0 fifo_test_mode_o |=> tx_fifo_peek_read_o
    ##1 hrdata_o == {24'h00_0000, $past(tx_fifo_head_i)}) else $error("peek wrong");
  AST_INJECT: assert property (s_wr(OFS_RFW) ##0 fifo_test_mode_o |=>
    ##1 rx_fifo_inject_o && inject_data_o == $past(wlo)) else $error("inject wrong");
endmodule

/* bench/umsft_peer.sv */
// Modem peer model driving the active-low control lines
`timescale 1ns/1ns
module umsft_peer (
  // Modem control lines, active low
  output umsft_pkg::umsft_modem_t modem_n_o
);
  import umsft_pkg::*;
  initial modem_n_o = MODEM_IDLE;
  // Lines move at any instant, unrelated to the bus clock
  task set_lines(input umsft_modem_t v, input int lag_ns);
    #(lag_ns);
    modem_n_o = v;
  endtask
endmodule

/* bench/test_uart_modem_status_fifo_test.sv */
// Self-checking bench for the modem status and FIFO test block
`timescale 1ns/1ns
module test_uart_modem_status_fifo_test;
  import umsft_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, dlab = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic [7:0] receive_buffer = 8'h00, txh = 8'h00;
  logic hreadyout_o, ftm, irq_o, hresp_o;
  logic [15:0] lpd;
  umsft_modem_t modem_n;
  int err_count = 0, n_compared = 0, cyc = 0;
  umsft_peer peer_u (.modem_n_o(modem_n));
  umsft_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .modem_n_i(modem_n), .line_control_dlab_i(dlab), .receive_buffer_i(receive_buffer),
    .transmit_holding_i(8'h00), .tx_fifo_head_i(txh), .receive_buffer_read_o(),
    .transmit_holding_write_o(), .transmit_holding_data_o(), .tx_fifo_peek_read_o(),
    .rx_fifo_inject_o(), .receive_buffer_inject_o(), .inject_data_o(),
    .fifo_test_mode_o(ftm), .low_power_divisor_o(lpd), .irq_o(irq_o));
  initial forever #25 clk_i = ~clk_i;
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task lines(input logic [3:0] v);
    peer_u.set_lines(v, 13);
    repeat (8) @(posedge clk_i);
  endtask
  task t_regs;
    rd("scr rst", OFS_SCR, 32'h0);
    rd("lpdl rst", OFS_LOW_POWER_DIVISOR_LOW, 32'h0);
    rd("far rst", OFS_FAR, 32'h0);
    rd("unmapped", 8'h90, 32'h0);
    wr(OFS_SCR, 32'hFFFF_FFA5);
    wr(OFS_LOW_POWER_DIVISOR_LOW, 32'h34);
    wr(OFS_LOW_POWER_DIVISOR_HIGH, 32'h12);
    rd("scr", OFS_SCR, 32'hA5);
    rd("lpdh", OFS_LOW_POWER_DIVISOR_HIGH, 32'h12);
    chk("divisor", 32'h1234, {16'h0, lpd});
  endtask
  task t_modem;
    logic [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 4'h1 << i;
      lines(~m);
      rd("msr set", OFS_MSR, {24'h0, m, m});
      lines(4'hF);
      rd("msr back", OFS_MSR, {24'h0, 4'h0, m});
      rd("msr clr", OFS_MSR, 32'h0);
    end
  endtask
  task t_irq;
    wr(OFS_INT_MASK, 32'h0);
    wr(OFS_INT_STAT, 32'h7);
    lines(4'hE);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rd("stat", OFS_INT_STAT, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    @(negedge clk_i);
    chk("irq on", 32'h1, {31'h0, irq_o});
    wr(OFS_INT_STAT, 32'h1);
    @(negedge clk_i);
    chk("irq off", 32'h0, {31'h0, irq_o});
    lines(4'hF);
    rd("msr cts", OFS_MSR, 32'h1);
  endtask
  task t_alias;
    @(posedge clk_i);
    receive_buffer <= 8'h5A;
    rd("alias lo", OFS_ALIAS_LO, 32'h5A);
    rd("alias hi", OFS_ALIAS_HI, 32'h5A);
    wr(8'h44, 32'h3C);
    dlab <= 1'b1;
    rd("alias shut", OFS_ALIAS_LO, 32'h0);
    wr(OFS_ALIAS_LO, 32'h11);
    dlab <= 1'b0;
  endtask
  task t_fifo;
    wr(OFS_FAR, 32'h1);
    rd("far", OFS_FAR, 32'h1);
    chk("test mode", 32'h1, {31'h0, ftm});
    txh <= 8'hC3;
    rd("peek", OFS_TFR, 32'hC3);
    wr(OFS_RFW, 32'h7E);
    // Modem, inject and alias write events are all pending by now
    rd("stat all", OFS_INT_STAT, 32'h7);
    chk("resp", 32'h0, {31'h0, hresp_o});
    wr(OFS_FAR, 32'h0);
    rd("peek off", OFS_TFR, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_modem;
    t_irq;
    t_alias;
    t_fifo;
    close_out;
  end
endmodule
bind umsft_top umsft_sva chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .modem_n_i(modem_n_i),
  .line_control_dlab_i(line_control_dlab_i), .receive_buffer_i(receive_buffer_i),
  .tx_fifo_head_i(tx_fifo_head_i), .receive_buffer_read_o(receive_buffer_read_o),
  .transmit_holding_write_o(transmit_holding_write_o),
  .transmit_holding_data_o(transmit_holding_data_o), .tx_fifo_peek_read_o(tx_fifo_peek_read_o),
  .rx_fifo_inject_o(rx_fifo_inject_o), .inject_data_o(inject_data_o),
  .fifo_test_mode_o(fifo_test_mode_o), .low_power_divisor_o(low_power_divisor_o));
